// ---- src/sar_tx_queues.sv ----
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
//==========================================
// Behaviour
// - segmenting flag set in memory during segmentation, host clears it beforehand.
// - chain flag one means next reference valid and is followed.
// - congestion and loss-priority flags set those header bits in every cell without pass-transparent.
// - pass-transparent takes congestion and CLP from circuit entry instead.
// - descriptor ten-bit MID copied into every cell.
// - abort flag sends one abort cell; host avoids continuation afterward.
// - completion flag raises interrupt when segmentation finishes.
// - circuit address is index shifted four plus base shifted eight.
// - remaining bytes loaded by host, device decrements and returns it.
// - size value sent as BAsize or AAL5 length field.
// - buffer reading starts at any 24-bit byte address.
// - AAL5 trailer control taken from final chained descriptor field.
// - utilization bits 11:8 weighted; totals above one flagged invalid.
// - sub-rate bits 7:6 pick 25, 50 or 100 percent.
// - queue bits 5:2 pick one of twelve peak-rate queues.
// - type bits 1:0 pick AAL34, transparent payload, transparent cell or AAL5.
// - bucket variable updated by device, constant kept as reference.
// - pending entry fetched when idle and at least every five periods.
// - release writes index, bumps write pointer, interrupts on completion flag.
module sar_tx_queues
   import sar_tx_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // shared memory master
   output logic mem_req,
   output logic mem_we,
   output logic [23:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // cell requests to segmenter
   output logic cell_valid,
   input wire logic cell_ready,
   output logic [31:0] cell_hdr,
   output logic [23:0] cell_buf_addr,
   output logic [9:0] cell_mid,
   output logic [15:0] cell_len,
   output logic [15:0] cell_ctrl,
   output logic cell_first,
   output logic cell_last,
   output logic cell_abort,
   output aal_t cell_aal,
   output logic [3:0] cell_queue,
   output logic [1:0] cell_subrate,
   output logic [3:0] cell_util,
   output logic [7:0] cell_bucket,
   // completion
   output logic completion_irq
);
   //==========================================
   // helpers
   function automatic logic [23:0] ring_next(input logic [23:0] p, input logic [23:0] s,
                                             input logic [23:0] e);
      ring_next = (p == e) ? s : p + WORD_STEP;
   endfunction

   function automatic logic [23:0] tbl_addr(input logic [15:0] base, input logic [11:0] idx);
      tbl_addr = (24'(base) << BASE_SHIFT) + (24'(idx) << IDX_SHIFT);
   endfunction

   //==========================================
   // state
   state_t state_reg;
   logic [15:0] desc_base_reg, circ_base_reg;
   logic [23:0] pq_start_reg, pq_end_reg, pq_wr_reg, pq_rd_reg;
   logic [23:0] rq_start_reg, rq_end_reg, rq_wr_reg, rq_rd_reg;
   logic [11:0] cur_idx_reg, hold_idx_reg;
   logic hold_v_reg, poll_ret_reg, first_reg, abort_done_reg;
   logic [1:0] word_reg;
   logic [2:0] period_reg;
   logic [7:0] flags_reg, bucket_reg;
   logic [9:0] mid_reg, circ_reg;
   logic [15:0] remain_reg, size_reg, next_reg;
   logic [23:0] buf_reg;
   logic [31:0] c_hdr_reg, c_par_reg;
   logic [23:0] mreq_addr;
   logic mreq_we;
   logic [31:0] mreq_data;
   logic [31:0] hdr_c;
   logic ack, ring_pending, util_err, mem_state, last_c;
   aal_t aal_c;

   assign ack = mem_req && mem_ack;
   assign ring_pending = pq_rd_reg != pq_wr_reg;
   assign aal_c = aal_t'(c_par_reg[C_ADAPTATION_TYPE_SELECT_LSB +: 2]);
   assign util_err = c_par_reg[C_UTIL_LSB + 3] && |c_par_reg[C_UTIL_LSB +: 3];
   assign mem_state = state_reg != IDLE && state_reg != SEG;
   assign last_c = flags_reg[F_ABORT] || remain_reg <= CELL_BYTES;

   //==========================================
   // header of next cell
   always_comb begin
      hdr_c = c_hdr_reg;
      if (!flags_reg[F_PASS]) begin
         hdr_c[HDR_CONG] = flags_reg[F_CONG];
         hdr_c[HDR_CLP] = flags_reg[F_CLP];
      end
      if (aal_c == AAL5) begin
         hdr_c[HDR_EOM] = last_c && !flags_reg[F_CHAIN];
      end
   end

   //==========================================
   // memory request per state
   always_comb begin
      mreq_addr = pq_rd_reg;
      mreq_we = 1'b0;
      mreq_data = '0;
      unique case (state_reg)
         IDLE, SEG, POLL: ;
         DESC: mreq_addr = tbl_addr(desc_base_reg, cur_idx_reg) + (24'(word_reg) << WORD_SHIFT);
         CIRC: mreq_addr = tbl_addr(circ_base_reg, 12'(circ_reg)) + (24'(word_reg) << WORD_SHIFT);
         MARK, CLOSE: begin
            mreq_addr = tbl_addr(desc_base_reg, cur_idx_reg) + (24'(word_reg) << WORD_SHIFT);
            mreq_we = 1'b1;
            if (word_reg == '0) begin
               mreq_data = (32'(flags_reg) << D_FLAGS_LSB) | (32'(mid_reg) << D_MID_LSB)
                           | (32'(circ_reg) << D_CIRC_LSB);
               mreq_data[D_FLAGS_LSB + F_SEG] = (state_reg == MARK);
            end else begin
               mreq_data = (32'(remain_reg) << D_REMAIN_LSB) | (32'(size_reg) << D_SIZE_LSB);
            end
         end
         BUCK: begin
            mreq_addr = tbl_addr(circ_base_reg, 12'(circ_reg)) + WORD_STEP;
            mreq_we = 1'b1;
            mreq_data = c_par_reg;
            mreq_data[C_MSTAR_LSB +: 8] = bucket_reg;
         end
         REL: begin
            mreq_addr = rq_wr_reg;
            mreq_we = 1'b1;
            mreq_data = 32'(cur_idx_reg);
         end
      endcase
   end

   //==========================================
   // memory port, one request held until ack
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= '0;
         mem_wdata <= '0;
      end else if (mem_req) begin
         if (mem_ack) begin
            mem_req <= 1'b0;
         end
      end else if (mem_state) begin
         mem_req <= 1'b1;
         mem_we <= mreq_we;
         mem_addr <= mreq_addr;
         mem_wdata <= mreq_data;
      end
   end

   //==========================================
   // host configuration
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         desc_base_reg <= '0;
         circ_base_reg <= '0;
         pq_start_reg <= '0;
         pq_end_reg <= '0;
         pq_wr_reg <= '0;
         rq_start_reg <= '0;
         rq_end_reg <= '0;
         rq_rd_reg <= '0;
      end else if (reg_wr) begin
         unique case (reg_addr[7:REG_IDX_LSB])
            IDX_DESC_BASE: desc_base_reg <= reg_wdata[15:0];
            IDX_CIRC_BASE: circ_base_reg <= reg_wdata[15:0];
            IDX_PQ_START: pq_start_reg <= reg_wdata[23:0];
            IDX_PQ_END: pq_end_reg <= reg_wdata[23:0];
            IDX_PQ_WR: pq_wr_reg <= reg_wdata[23:0];
            IDX_RQ_START: rq_start_reg <= reg_wdata[23:0];
            IDX_RQ_END: rq_end_reg <= reg_wdata[23:0];
            IDX_RQ_RD: rq_rd_reg <= reg_wdata[23:0];
            default: ;
         endcase
      end
   end

   //==========================================
   // register read, data one cycle after strobe
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            unique case (reg_addr[7:REG_IDX_LSB])
               IDX_DESC_BASE: reg_rdata <= 32'(desc_base_reg);
               IDX_CIRC_BASE: reg_rdata <= 32'(circ_base_reg);
               IDX_PQ_START: reg_rdata <= 32'(pq_start_reg);
               IDX_PQ_END: reg_rdata <= 32'(pq_end_reg);
               IDX_PQ_WR: reg_rdata <= 32'(pq_wr_reg);
               IDX_PQ_RD: reg_rdata <= 32'(pq_rd_reg);
               IDX_RQ_START: reg_rdata <= 32'(rq_start_reg);
               IDX_RQ_END: reg_rdata <= 32'(rq_end_reg);
               IDX_RQ_WR: reg_rdata <= 32'(rq_wr_reg);
               IDX_RQ_RD: reg_rdata <= 32'(rq_rd_reg);
               IDX_STATUS: begin
                  reg_rdata[ST_BUSY] <= state_reg != IDLE;
                  reg_rdata[ST_HOLD] <= hold_v_reg;
                  reg_rdata[ST_UTIL_ERR] <= util_err;
                  reg_rdata[ST_PENDING] <= ring_pending;
               end
               default: ;
            endcase
         end
      end
   end

   //==========================================
   // queue sequencer
   // host may rewrite the device-owned pointers; a write while busy races the engine
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= IDLE;
         pq_rd_reg <= '0;
         rq_wr_reg <= '0;
         cur_idx_reg <= '0;
         hold_idx_reg <= '0;
         hold_v_reg <= 1'b0;
         poll_ret_reg <= 1'b0;
         first_reg <= 1'b0;
         abort_done_reg <= 1'b0;
         word_reg <= '0;
         period_reg <= '0;
         flags_reg <= '0;
         bucket_reg <= '0;
         mid_reg <= '0;
         circ_reg <= '0;
         remain_reg <= '0;
         size_reg <= '0;
         next_reg <= '0;
         buf_reg <= '0;
         c_hdr_reg <= '0;
         c_par_reg <= '0;
         completion_irq <= 1'b0;
         cell_valid <= 1'b0;
         cell_hdr <= '0;
         cell_buf_addr <= '0;
         cell_mid <= '0;
         cell_len <= '0;
         cell_ctrl <= '0;
         cell_first <= 1'b0;
         cell_last <= 1'b0;
         cell_abort <= 1'b0;
         cell_aal <= AAL34;
         cell_queue <= '0;
         cell_subrate <= '0;
         cell_util <= '0;
         cell_bucket <= '0;
      end else begin
         completion_irq <= 1'b0;
         if (cell_ready) begin
            cell_valid <= 1'b0;
         end
         if (reg_wr && reg_addr[7:REG_IDX_LSB] == IDX_PQ_RD) begin
            pq_rd_reg <= reg_wdata[23:0];
         end
         if (reg_wr && reg_addr[7:REG_IDX_LSB] == IDX_RQ_WR) begin
            rq_wr_reg <= reg_wdata[23:0];
         end
         unique case (state_reg)
            IDLE: begin
               word_reg <= '0;
               if (hold_v_reg) begin
                  cur_idx_reg <= hold_idx_reg;
                  hold_v_reg <= 1'b0;
                  state_reg <= DESC;
               end else if (ring_pending) begin
                  poll_ret_reg <= 1'b0;
                  state_reg <= POLL;
               end
            end
            POLL: if (ack) begin
               hold_idx_reg <= mem_rdata[11:0];
               hold_v_reg <= 1'b1;
               pq_rd_reg <= ring_next(pq_rd_reg, pq_start_reg, pq_end_reg);
               period_reg <= '0;
               state_reg <= poll_ret_reg ? SEG : IDLE;
            end
            DESC: if (ack) begin
               unique case (word_reg)
                  2'h0: begin
                     flags_reg <= mem_rdata[D_FLAGS_LSB +: 8];
                     mid_reg <= mem_rdata[D_MID_LSB +: 10];
                     circ_reg <= mem_rdata[D_CIRC_LSB +: 10];
                  end
                  2'h1: begin
                     remain_reg <= mem_rdata[D_REMAIN_LSB +: 16];
                     size_reg <= mem_rdata[D_SIZE_LSB +: 16];
                  end
                  2'h2: buf_reg <= mem_rdata[23:0];
                  2'h3: next_reg <= mem_rdata[15:0];
               endcase
               word_reg <= word_reg + 2'h1;
               if (word_reg == DESC_LAST) begin
                  state_reg <= CIRC;
               end
            end
            CIRC: if (ack) begin
               if (word_reg == '0) begin
                  c_hdr_reg <= mem_rdata;
                  word_reg <= word_reg + 2'h1;
               end else begin
                  c_par_reg <= mem_rdata;
                  bucket_reg <= mem_rdata[C_MSTAR_LSB +: 8];
                  word_reg <= '0;
                  first_reg <= 1'b1;
                  abort_done_reg <= 1'b0;
                  period_reg <= '0;
                  state_reg <= MARK;
               end
            end
            MARK: if (ack) begin
               flags_reg[F_SEG] <= 1'b1;
               state_reg <= SEG;
            end
            SEG: begin
               if (period_reg == POLL_PERIODS && !hold_v_reg && ring_pending) begin
                  poll_ret_reg <= 1'b1;
                  state_reg <= POLL;
               end else if (!cell_valid || cell_ready) begin
                  if (remain_reg == '0 || abort_done_reg) begin
                     word_reg <= '0;
                     state_reg <= CLOSE;
                  end else begin
                     cell_valid <= 1'b1;
                     cell_hdr <= hdr_c;
                     cell_buf_addr <= buf_reg;
                     buf_reg <= buf_reg + 24'(CELL_BYTES);
                     cell_mid <= mid_reg;
                     cell_len <= size_reg;
                     cell_ctrl <= (aal_c == AAL5 && !flags_reg[F_CHAIN]) ? next_reg : '0;
                     cell_first <= first_reg && !flags_reg[F_CONT];
                     first_reg <= 1'b0;
                     cell_last <= last_c;
                     cell_abort <= flags_reg[F_ABORT];
                     abort_done_reg <= flags_reg[F_ABORT];
                     remain_reg <= last_c ? '0 : remain_reg - CELL_BYTES;
                     cell_aal <= aal_c;
                     cell_queue <= c_par_reg[C_SQN_LSB +: 4];
                     cell_subrate <= c_par_reg[C_SRS_LSB +: 2];
                     cell_util <= c_par_reg[C_UTIL_LSB +: 4];
                     cell_bucket <= bucket_reg;
                     bucket_reg <= (bucket_reg != '0) ? bucket_reg - 8'h01 : '0;
                     if (period_reg != POLL_PERIODS) begin
                        period_reg <= period_reg + 3'h1;
                     end
                  end
               end
            end
            CLOSE: if (ack) begin
               word_reg <= word_reg + 2'h1;
               if (word_reg == '0) begin
                  flags_reg[F_SEG] <= 1'b0;
               end else begin
                  state_reg <= BUCK;
               end
            end
            BUCK: if (ack) begin
               state_reg <= REL;
            end
            REL: if (ack) begin
               rq_wr_reg <= ring_next(rq_wr_reg, rq_start_reg, rq_end_reg);
               completion_irq <= flags_reg[F_IOC];
               word_reg <= '0;
               if (flags_reg[F_CHAIN]) begin
                  cur_idx_reg <= next_reg[11:0];
                  state_reg <= DESC;
               end else begin
                  state_reg <= IDLE;
               end
            end
         endcase
      end
   end

   //==========================================
   // checks
   mark_write_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == MARK && mem_req) |-> mem_we && mem_wdata[D_FLAGS_LSB + F_SEG])
      else $error("segmenting flag not written");
   chain_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == REL && ack && flags_reg[F_CHAIN]) |=>
      state_reg == DESC && cur_idx_reg == $past(next_reg[11:0]))
      else $error("chain not followed");
   cong_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(cell_valid) && !flags_reg[F_PASS] |->
      cell_hdr[HDR_CONG] == flags_reg[F_CONG] && cell_hdr[HDR_CLP] == flags_reg[F_CLP])
      else $error("descriptor header bits wrong");
   pass_bits_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(cell_valid) && flags_reg[F_PASS] |->
      cell_hdr[HDR_CLP] == c_hdr_reg[HDR_CLP] && cell_hdr[HDR_CONG] == c_hdr_reg[HDR_CONG])
      else $error("transparent header bits wrong");
   mid_copy_a: assert property (@(posedge sys_clk) disable iff (rst)
      cell_valid |-> cell_mid == mid_reg && cell_len == size_reg)
      else $error("mid or length mismatch");
   abort_one_a: assert property (@(posedge sys_clk) disable iff (rst)
      (cell_valid && cell_ready && cell_abort) |=> !cell_valid)
      else $error("cell after abort");
   irq_done_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == REL && ack) |=> completion_irq == $past(flags_reg[F_IOC]) ##1 !completion_irq)
      else $error("completion interrupt wrong");
   circ_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == CIRC && mem_req && word_reg == '0) |->
      mem_addr == (24'(circ_base_reg) << BASE_SHIFT) + (24'(circ_reg) << IDX_SHIFT))
      else $error("circuit address wrong");
   ctrl_field_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(cell_valid) && aal_c == AAL5 && !flags_reg[F_CHAIN] |-> cell_ctrl == next_reg)
      else $error("trailer control wrong");
   poll_period_a: assert property (@(posedge sys_clk) disable iff (rst)
      period_reg <= POLL_PERIODS)
      else $error("poll period overrun");
   rel_ptr_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == REL && ack && !reg_wr) |=>
      rq_wr_reg == ($past(rq_wr_reg) == rq_end_reg ? rq_start_reg : $past(rq_wr_reg) + WORD_STEP))
      else $error("release pointer not advanced");
endmodule

// ---- src/sar_tx_pkg.sv ----
package sar_tx_pkg;
   // register indices, byte address is index times four
   localparam logic [5:0] IDX_DESC_BASE = 6'h00;
   localparam logic [5:0] IDX_CIRC_BASE = 6'h01;
   localparam logic [5:0] IDX_PQ_START = 6'h03;
   localparam logic [5:0] IDX_PQ_END = 6'h04;
   localparam logic [5:0] IDX_PQ_WR = 6'h05;
   localparam logic [5:0] IDX_PQ_RD = 6'h06;
   localparam logic [5:0] IDX_RQ_START = 6'h07;
   localparam logic [5:0] IDX_RQ_END = 6'h08;
   localparam logic [5:0] IDX_RQ_WR = 6'h09;
   localparam logic [5:0] IDX_RQ_RD = 6'h0A;
   localparam logic [5:0] IDX_STATUS = 6'h12;
   localparam int REG_IDX_LSB = 2;
   // status bits
   localparam int ST_BUSY = 0;
   localparam int ST_HOLD = 1;
   localparam int ST_UTIL_ERR = 2;
   localparam int ST_PENDING = 3;
   // descriptor flag byte, word 0 bits 31:24
   localparam int F_SEG = 7;
   localparam int F_CHAIN = 6;
   localparam int F_CONT = 5;
   localparam int F_CONG = 4;
   localparam int F_PASS = 3;
   localparam int F_ABORT = 2;
   localparam int F_IOC = 1;
   localparam int F_CLP = 0;
   localparam int D_FLAGS_LSB = 24;
   localparam int D_MID_LSB = 10;
   localparam int D_CIRC_LSB = 0;
   localparam int D_REMAIN_LSB = 16;
   localparam int D_SIZE_LSB = 0;
   // circuit entry word 1
   localparam int C_MSTAR_LSB = 24;
   localparam int C_M_LSB = 16;
   localparam int C_UTIL_LSB = 8;
   localparam int C_SRS_LSB = 6;
   localparam int C_SQN_LSB = 2;
   localparam int C_ADAPTATION_TYPE_SELECT_LSB = 0;
   // cell header bits
   localparam int HDR_CONG = 2;
   localparam int HDR_EOM = 1;
   localparam int HDR_CLP = 0;
   // address forming
   localparam int BASE_SHIFT = 8;
   localparam int IDX_SHIFT = 4;
   localparam int WORD_SHIFT = 2;
   localparam logic [23:0] WORD_STEP = 24'h000004;
   localparam logic [15:0] CELL_BYTES = 16'h0030;
   localparam logic [1:0] DESC_LAST = 2'h3;
   localparam logic [1:0] CIRC_LAST = 2'h1;
   localparam logic [2:0] POLL_PERIODS = 3'h5;
   typedef enum logic [1:0] {
      AAL34 = 2'b00, TR_PAYLOAD = 2'b01, TR_CELL = 2'b10, AAL5 = 2'b11
   } aal_t;
   typedef enum logic [3:0] {
      IDLE = 4'b0000, POLL = 4'b0001, DESC = 4'b0010, CIRC = 4'b0011,
      MARK = 4'b0100, SEG = 4'b0101, CLOSE = 4'b0110, BUCK = 4'b0111,
      REL = 4'b1000
   } state_t;
endpackage

// ---- verification/sar_mem_model.sv ----
`timescale 1ns/1ps
//==========================================
// shared memory on the far side of the engine
module sar_mem_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // memory port
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [23:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   // wait states before each ack
   input wire logic [1:0] slow
);
   logic [31:0] mem [0:1023];
   logic [1:0] wait_reg;
   // data only meaningful with ack, inverted otherwise so stale data never looks right
   assign mem_rdata = mem_ack ? mem[mem_addr[11:2]] : ~mem[mem_addr[11:2]];
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mem_ack <= 1'b0;
         wait_reg <= 2'h0;
      end else if (mem_req && !mem_ack && wait_reg == slow) begin
         mem_ack <= 1'b1;
         wait_reg <= 2'h0;
         if (mem_we) begin
            mem[mem_addr[11:2]] <= mem_wdata;
         end
      end else begin
         mem_ack <= 1'b0;
         wait_reg <= (mem_req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
      end
   end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
//==========================================
// descriptor rings, cells and release through the register port
module tb_top
   import sar_tx_pkg::*;
;
   typedef struct packed {logic [6:0] idx; logic [1:0] skip; logic [17:0] hm; logic [101:0] dm;} exp_t;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cell_ready = 1'b0;
   logic [1:0] slow = 2'h0;
   logic [31:0] reg_rdata, mem_wdata, mem_rdata, cell_hdr, rd;
   logic mem_req, mem_we, mem_ack, cell_valid, cell_first, cell_last, cell_abort, completion_irq;
   logic [23:0] mem_addr, cell_buf_addr;
   logic [9:0] cell_mid;
   logic [15:0] cell_len, cell_ctrl;
   aal_t cell_aal;
   logic [3:0] cell_queue, cell_util;
   logic [1:0] cell_subrate;
   logic [7:0] cell_bucket;
   logic [101:0] dmk;
   exp_t exp_q[$];
   exp_t e;
   int error_cnt = 0;
   int samples_checked = 0;
   int irq_cnt = 0;
   int cyc = 0;
   sar_tx_queues sar_tx_queues_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .cell_valid(cell_valid), .cell_ready(cell_ready), .cell_hdr(cell_hdr), .cell_buf_addr(cell_buf_addr),
      .cell_mid(cell_mid), .cell_len(cell_len), .cell_ctrl(cell_ctrl), .cell_first(cell_first),
      .cell_last(cell_last), .cell_abort(cell_abort), .cell_aal(cell_aal), .cell_queue(cell_queue),
      .cell_subrate(cell_subrate), .cell_util(cell_util), .cell_bucket(cell_bucket),
      .completion_irq(completion_irq));
   sar_mem_model sar_mem_model_inst (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow));
   task close_out;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task check(input string name, input logic [127:0] exp, input logic [127:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task poke(input int a, input logic [31:0] d);
      sar_mem_model_inst.mem[a[11:2]] = d;
   endtask
   function automatic logic [31:0] peek(input int a);
      return sar_mem_model_inst.mem[a[11:2]];
   endfunction
   task wr(input logic [5:0] i, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= {i, 2'b00};
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rdr(input logic [5:0] i);
      @(posedge sys_clk);
      reg_addr <= {i, 2'b00};
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask
   // host keeps segmenting, continuation and reserved bits clear
   task desc(input int a, input logic [7:0] fl, input logic [9:0] mid, input logic [9:0] ci,
             input logic [31:0] w1, input logic [23:0] st, input logic [15:0] w3);
      poke(a, {fl, 4'h0, mid, ci});
      poke(a + 4, w1);
      poke(a + 8, {8'h00, st});
      poke(a + 12, {16'h0000, w3});
   endtask
   task xp(input logic [6:0] i, input logic [1:0] s, input logic [17:0] hm, input logic [101:0] dm);
      exp_q.push_back('{i, s, hm, dm});
   endtask
   // ready stalls one cycle in four so cells wait at the port
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      cell_ready <= (cyc % 4) != 0;
      if (completion_irq) begin
         irq_cnt++;
      end
      if (cell_valid && cell_ready) begin
         e = exp_q.pop_front();
         dmk = e.skip == 2'h2 ? '0 : e.skip == 2'h1 ? ~(102'hFFFF << 8) : '1;
         check("seg flag", 1'b1, peek(32'h100 + 16 * e.idx) >> 31);
         check("cell mode", e.hm, {cell_first, cell_hdr[HDR_EOM], cell_hdr[HDR_CONG], cell_hdr[HDR_CLP],
               cell_abort, cell_last, cell_aal, cell_queue, cell_subrate, cell_util});
         check("cell data", e.dm & dmk, {cell_hdr[31:4], cell_buf_addr, cell_mid, cell_len, cell_ctrl,
               cell_bucket} & dmk);
      end
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      poke(32'h200, 32'h0ABCDEF0);
      poke(32'h204, 32'h202008B0);
      poke(32'h210, 32'h01234560);
      poke(32'h214, 32'h10100447);
      desc(32'h100, 8'h13, 10'h155, 10'h001, 32'h00601234, 24'h000401, 16'h00A5);
      desc(32'h110, 8'h19, 10'h3FF, 10'h000, 32'h00300030, 24'h000600, 16'h0000);
      desc(32'h120, 8'h04, 10'h000, 10'h000, 32'h00600030, 24'h000640, 16'h0000);
      desc(32'h130, 8'h40, 10'h000, 10'h001, 32'h00300060, 24'h000700, 16'h0004);
      desc(32'h140, 8'h02, 10'h2AA, 10'h001, 32'h00300090, 24'h000800, 16'h005A);
      xp(7'h0, 2'h0, 18'h2CC54, {28'h0123456, 24'h000401, 10'h155, 16'h1234, 16'h00A5, 8'h10});
      xp(7'h0, 2'h0, 18'h1DC54, {28'h0123456, 24'h000431, 10'h155, 16'h1234, 16'h00A5, 8'h0F});
      xp(7'h1, 2'h0, 18'h21328, {28'h0ABCDEF, 24'h000600, 10'h3FF, 16'h0030, 16'h0000, 8'h20});
      xp(7'h2, 2'h0, 18'h23328, {28'h0ABCDEF, 24'h000640, 10'h000, 16'h0030, 16'h0000, 8'h1F});
      xp(7'h3, 2'h0, 18'h21C54, {28'h0123456, 24'h000700, 10'h000, 16'h0060, 16'h0000, 8'h0E});
      xp(7'h4, 2'h0, 18'h31C54, {28'h0123456, 24'h000800, 10'h2AA, 16'h0090, 16'h005A, 8'h0D});
      poke(32'h300, 32'h0);
      poke(32'h304, 32'h1);
      poke(32'h308, 32'h2);
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      wr(IDX_DESC_BASE, 32'h1);
      wr(IDX_CIRC_BASE, 32'h2);
      wr(IDX_PQ_START, 32'h300);
      wr(IDX_PQ_END, 32'h30C);
      wr(IDX_RQ_START, 32'h340);
      wr(IDX_RQ_END, 32'h35C);
      wr(IDX_RQ_WR, 32'h340);
      wr(IDX_RQ_RD, 32'h340);
      wr(IDX_PQ_RD, 32'h300);
      wr(IDX_PQ_WR, 32'h30C);
      rdr(6'h0B);
      check("unmapped read", 32'h0, rd);
      for (int n = 0; n < 400 && rd !== 32'h34C; n++) rdr(IDX_RQ_WR);
      slow <= 2'h2;
      poke(32'h30C, 32'h3);
      wr(IDX_PQ_WR, 32'h300);
      for (int n = 0; n < 400 && rd !== 32'h354; n++) rdr(IDX_RQ_WR);
      for (int n = 0; n < 5; n++) check("release entry", n, peek(32'h340 + 4 * n));
      rdr(IDX_RQ_WR);
      check("release wr ptr", 32'h354, rd);
      rdr(IDX_PQ_RD);
      check("pending rd ptr", 32'h300, rd);
      check("irq count", 2, irq_cnt);
      check("cells left", 0, exp_q.size());
      check("seg flag clear", 0, peek(32'h100) >> 31);
      check("remaining", 32'h00001234, peek(32'h104));
      check("bucket var", 16'h0C10, peek(32'h214) >> 16);
      close_out();
   end
endmodule
